// >>> hw/dcc_regs.svh
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
// register byte addresses
`define DCC_ADDR_CONTROL 12'h000
`define DCC_ADDR_FLAGS 12'h004
`define DCC_ADDR_ENABLES 12'h008
`define DCC_ADDR_PORT 12'h00C
// comparator_control fields
`define DCC_BIT_B_OUT 7
`define DCC_BIT_A_OUT 6
`define DCC_BIT_B_INV 5
`define DCC_BIT_A_INV 4
`define DCC_BIT_SWITCH 3
`define DCC_CONTROL_RESET 8'h07
// flag register: change flag at bit six
`define DCC_BIT_FLAG 6
// enable register: change enable, peripheral enable, global enable
`define DCC_BIT_EN_CHANGE 0
`define DCC_BIT_EN_PERIPH 1
`define DCC_BIT_EN_GLOBAL 2
// port register: latch 5:0, direction 13:8, analog config 19:16
`define DCC_PORT_LAT_LSB 0
`define DCC_PORT_DIR_LSB 8
`define DCC_PORT_CFG_LSB 16
`define DCC_DIR_RESET 6'h3F
`define DCC_CFG_RESET 4'h0
`endif

// >>> hw/dcc_pkg.sv
package dcc_pkg;
   typedef enum logic [2:0] {
      DCC_MODE_0 = 3'b000,
      DCC_MODE_1 = 3'b001,
      DCC_MODE_2 = 3'b010,
      DCC_MODE_3 = 3'b011,
      DCC_MODE_4 = 3'b100,
      DCC_MODE_5 = 3'b101,
      DCC_MODE_MUX4 = 3'b110,
      DCC_MODE_OFF = 3'b111
   } dcc_mode_type;
   typedef struct packed {
      logic [5:0] pin_in;
      logic [3:0] cmp_gt;
      logic [1:0] ref_gt;
   } dcc_analog_type;
   typedef struct packed {
      logic [5:0] pin_out;
      logic [5:0] pin_oe_n;
   } dcc_pins_type;
endpackage : dcc_pkg

// >>> hw/dcc_top.sv
`timescale 1ns/100ps
`include "dcc_regs.svh"
// Overview of operation
// - three-bit mode field selects eight modes
// - output high when plus input exceeds minus
// - internal reference drives plus inputs, mode 110
// - output status bits read-only in control
// - routing puts comparator outputs, after the invert bits, on pins
// - direction bits still enable routed pins
// - invert bits five, four flip outputs
// - flag sets on either output change
// - write zero clears flag, one sets
// - interrupt needs change, peripheral, global enables
// - flag sets even when enables clear
// - change during control read may miss flag
// - control access ends mismatch condition
// - persisting mismatch keeps setting flag
// - comparators and interrupt run in sleep
// - wake leaves control register unchanged
// - reset returns control, mode 111 off
// - analog-configured pins read zero from port
// - input pins 0..3 analog after reset, config bits
// - input switch picks minus pins in mux mode
module dcc_top (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog front end
   input wire dcc_pkg::dcc_analog_type analog,
   output logic [1:0] cmp_enable,
   output logic ref_select,
   output logic input_switch,
   // port pins
   output dcc_pkg::dcc_pins_type pins,
   // interrupt and sleep
   input wire logic sleeping,
   output logic irq,
   output logic wake
);
   import dcc_pkg::*;

   // ************************************************************
   // registers
   // ************************************************************
   dcc_mode_type comparator_mode_field;
   logic cmp_a_invert;
   logic cmp_b_invert;
   logic cmp_change_flag;
   logic [2:0] enables;
   logic [5:0] port_latch;
   logic [5:0] port_a_direction;
   logic [3:0] port_analog_config;
   logic [1:0] seen_out;
   logic sw_bit;

   // ************************************************************
   // comparator paths
   // ************************************************************
   logic [1:0] raw_out;
   logic [1:0] cmp_out;
   logic cmp_a_output;
   logic cmp_b_output;
   logic [5:0] analog_pin;
   logic mismatch;
   logic ctrl_access;
   logic apb_write;
   logic apb_read;

   assign apb_write = psel && penable && pwrite;
   assign apb_read = psel && penable && !pwrite;
   assign ctrl_access = psel && penable && (paddr == `DCC_ADDR_CONTROL);

   // analog front end reports plus>minus per input; mode picks source
   always_comb begin
      raw_out = 2'b00;
      case (comparator_mode_field)
         DCC_MODE_OFF: raw_out = 2'b00;
         DCC_MODE_MUX4: raw_out = analog.ref_gt;
         default: raw_out = analog.cmp_gt[1:0];
      endcase
   end

   assign cmp_enable = (comparator_mode_field == DCC_MODE_OFF) ? 2'b00 : 2'b11;
   assign ref_select = (comparator_mode_field == DCC_MODE_MUX4);
   assign input_switch = sw_bit;
   assign cmp_a_output = raw_out[0] ^ cmp_a_invert;
   assign cmp_b_output = raw_out[1] ^ cmp_b_invert;
   assign cmp_out = {cmp_b_output, cmp_a_output};
   assign mismatch = (cmp_out != seen_out);

   property p_ref_source;
      @(posedge mclk) disable iff (!nrst)
      ref_select |-> (raw_out == analog.ref_gt);
   endproperty
   a_ref_source: assert property (p_ref_source) else $error("reference path wrong");

   property p_plain_source;
      @(posedge mclk) disable iff (!nrst)
      (cmp_enable == 2'b11 && !ref_select) |-> (raw_out == analog.cmp_gt[1:0]);
   endproperty
   a_plain_source: assert property (p_plain_source) else $error("input path wrong");

   property p_off_quiet;
      @(posedge mclk) disable iff (!nrst)
      (comparator_mode_field == DCC_MODE_OFF) |-> (raw_out == 2'b00 && !ref_select);
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("off mode output");

   property p_on_modes;
      @(posedge mclk) disable iff (!nrst)
      (comparator_mode_field != DCC_MODE_OFF) |-> (cmp_enable == 2'b11);
   endproperty
   a_on_modes: assert property (p_on_modes) else $error("comparators not on");

   // ************************************************************
   // control register
   // ************************************************************
   // sleep is not an input here: wake never disturbs state
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         comparator_mode_field <= DCC_MODE_OFF;
         cmp_a_invert <= 1'b0;
         cmp_b_invert <= 1'b0;
         sw_bit <= 1'b0;
      end else if (apb_write && paddr == `DCC_ADDR_CONTROL) begin
         comparator_mode_field <= dcc_mode_type'(pwdata[2:0]);
         sw_bit <= pwdata[`DCC_BIT_SWITCH];
         cmp_a_invert <= pwdata[`DCC_BIT_A_INV];
         cmp_b_invert <= pwdata[`DCC_BIT_B_INV];
         // output bits 7:6 are not stored; writes have no effect
      end
   end

   property p_mode_store;
      @(posedge mclk) disable iff (!nrst)
      (apb_write && paddr == `DCC_ADDR_CONTROL)
         |=> (comparator_mode_field == $past(pwdata[2:0]));
   endproperty
   a_mode_store: assert property (p_mode_store) else $error("mode not stored");

   property p_switch_store;
      @(posedge mclk) disable iff (!nrst)
      (apb_write && paddr == `DCC_ADDR_CONTROL)
         |=> (input_switch == $past(pwdata[`DCC_BIT_SWITCH]));
   endproperty
   a_switch_store: assert property (p_switch_store) else $error("switch not stored");

   property p_control_held;
      @(posedge mclk) disable iff (!nrst)
      !(apb_write && paddr == `DCC_ADDR_CONTROL)
         |=> ($stable(comparator_mode_field) && $stable(sw_bit) && $stable(cmp_b_invert));
   endproperty
   a_control_held: assert property (p_control_held) else $error("control changed");

   // copy latched at every control access ends mismatch
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         seen_out <= 2'b00;
      end else if (ctrl_access) begin
         seen_out <= cmp_out;
      end
   end

   // ************************************************************
   // change flag and interrupt
   // ************************************************************
   logic flag_write;

   assign flag_write = apb_write && (paddr == `DCC_ADDR_FLAGS);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cmp_change_flag <= 1'b0;
      end else if (mismatch && !ctrl_access) begin
         // a change coinciding with the control access is missed
         cmp_change_flag <= 1'b1;
      end else if (flag_write) begin
         cmp_change_flag <= pwdata[`DCC_BIT_FLAG];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         enables <= 3'b000;
      end else if (apb_write && paddr == `DCC_ADDR_ENABLES) begin
         enables <= pwdata[2:0];
      end
   end

   assign irq = cmp_change_flag && enables[`DCC_BIT_EN_CHANGE]
      && enables[`DCC_BIT_EN_PERIPH] && enables[`DCC_BIT_EN_GLOBAL];
   // wake needs only the source enable; the core clock keeps running here
   assign wake = sleeping && cmp_change_flag && enables[`DCC_BIT_EN_CHANGE];

   property p_flag_soft_set;
      @(posedge mclk) disable iff (!nrst)
      (flag_write && pwdata[`DCC_BIT_FLAG]) |=> cmp_change_flag;
   endproperty
   a_flag_soft_set: assert property (p_flag_soft_set) else $error("soft set failed");

   property p_access_miss;
      @(posedge mclk) disable iff (!nrst)
      (ctrl_access && !cmp_change_flag) |=> !cmp_change_flag;
   endproperty
   a_access_miss: assert property (p_access_miss) else $error("flag set on access");

   property p_irq_masked;
      @(posedge mclk) disable iff (!nrst)
      (enables != 3'b111) |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq not masked");

   property p_sleep_wake;
      @(posedge mclk) disable iff (!nrst)
      (sleeping && irq) |-> wake;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("no wake");

   // ************************************************************
   // port registers and pins
   // ************************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         port_latch <= 6'h00;
         port_a_direction <= `DCC_DIR_RESET;
         port_analog_config <= `DCC_CFG_RESET;
      end else if (apb_write && paddr == `DCC_ADDR_PORT) begin
         port_latch <= pwdata[`DCC_PORT_LAT_LSB +: 6];
         port_a_direction <= pwdata[`DCC_PORT_DIR_LSB +: 6];
         port_analog_config <= pwdata[`DCC_PORT_CFG_LSB +: 4];
      end
   end

   // pin n of 0..3 analog while config below 15-n (all analog at 0)
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_pin
         if (gi < 4) begin : g_an
            assign analog_pin[gi] = (port_analog_config < 4'(15 - gi));
         end else begin : g_dig
            assign analog_pin[gi] = 1'b0;
         end
      end
   endgenerate

   logic route_en;
   // routing active in the modes that bring outputs out
   assign route_en = (comparator_mode_field == DCC_MODE_5)
      || (comparator_mode_field == DCC_MODE_3);

   always_comb begin
      pins.pin_out = port_latch;
      if (route_en) begin
         pins.pin_out[4] = cmp_a_output;
         pins.pin_out[5] = cmp_b_output;
      end
      pins.pin_oe_n = port_a_direction;
   end

   property p_dir_enables;
      @(posedge mclk) disable iff (!nrst)
      pins.pin_oe_n == port_a_direction;
   endproperty
   a_dir_enables: assert property (p_dir_enables) else $error("pin enable wrong");

   property p_latch_out;
      @(posedge mclk) disable iff (!nrst)
      !route_en |-> (pins.pin_out == port_latch);
   endproperty
   a_latch_out: assert property (p_latch_out) else $error("latch not on pins");

   property p_reset_analog;
      @(posedge mclk) disable iff (!nrst)
      (port_analog_config == `DCC_CFG_RESET) |-> (analog_pin[3:0] == 4'hF);
   endproperty
   a_reset_analog: assert property (p_reset_analog) else $error("pins not analog");

   // ************************************************************
   // apb read
   // ************************************************************
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (paddr == `DCC_ADDR_CONTROL) begin
         next_prdata[7:0] = {cmp_b_output, cmp_a_output, cmp_b_invert,
            cmp_a_invert, sw_bit, comparator_mode_field};
      end else if (paddr == `DCC_ADDR_FLAGS) begin
         next_prdata[`DCC_BIT_FLAG] = cmp_change_flag;
      end else if (paddr == `DCC_ADDR_ENABLES) begin
         next_prdata[2:0] = enables;
      end else if (paddr == `DCC_ADDR_PORT) begin
         next_prdata[`DCC_PORT_LAT_LSB +: 6] = analog.pin_in & ~analog_pin;
         next_prdata[`DCC_PORT_DIR_LSB +: 6] = port_a_direction;
         next_prdata[`DCC_PORT_CFG_LSB +: 4] = port_analog_config;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   property p_out_status;
      @(posedge mclk) disable iff (!nrst)
      (apb_read && paddr == `DCC_ADDR_CONTROL) |-> (prdata[7:6] == $past(cmp_out));
   endproperty
   a_out_status: assert property (p_out_status) else $error("status bits wrong");

   property p_analog_zero;
      @(posedge mclk) disable iff (!nrst)
      (apb_read && paddr == `DCC_ADDR_PORT) |-> ((prdata[5:0] & $past(analog_pin)) == 6'h00);
   endproperty
   a_analog_zero: assert property (p_analog_zero) else $error("analog pin read");

   // ************************************************************
   // checks
   // ************************************************************
   property p_flag_on_change;
      @(posedge mclk) disable iff (!nrst)
      (mismatch && !ctrl_access) |=> cmp_change_flag;
   endproperty
   a_flag_on_change: assert property (p_flag_on_change) else $error("flag missed");

   property p_irq_gate;
      @(posedge mclk) disable iff (!nrst)
      irq |-> (cmp_change_flag && enables == 3'b111);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");

   property p_access_clears;
      @(posedge mclk) disable iff (!nrst)
      ctrl_access && $stable(cmp_out) ##1 $stable(cmp_out) |-> !mismatch;
   endproperty
   a_access_clears: assert property (p_access_clears) else $error("mismatch kept");

   property p_clear_zero;
      @(posedge mclk) disable iff (!nrst)
      (flag_write && !pwdata[`DCC_BIT_FLAG] && !mismatch) |=> !cmp_change_flag;
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("clear failed");

   property p_mismatch_holds;
      @(posedge mclk) disable iff (!nrst)
      (mismatch && !ctrl_access) [*2] |-> cmp_change_flag;
   endproperty
   a_mismatch_holds: assert property (p_mismatch_holds) else $error("flag dropped");

   property p_route;
      @(posedge mclk) disable iff (!nrst)
      route_en |-> (pins.pin_out[4] == cmp_a_output && pins.pin_out[5] == cmp_b_output);
   endproperty
   a_route: assert property (p_route) else $error("route wrong");

   property p_ctrl_write;
      @(posedge mclk) disable iff (!nrst)
      (apb_write && paddr == `DCC_ADDR_CONTROL)
         |=> (cmp_a_invert == $past(pwdata[`DCC_BIT_A_INV]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("invert not stored");

   property p_off_mode;
      @(posedge mclk) disable iff (!nrst)
      (comparator_mode_field == DCC_MODE_OFF) |-> (cmp_enable == 2'b00);
   endproperty
   a_off_mode: assert property (p_off_mode) else $error("off mode active");
endmodule : dcc_top

// >>> bench/testbench.sv
`timescale 1ns/100ps
`include "dcc_regs.svh"
module testbench;
   import dcc_pkg::*;
   // ********
   // signals
   // ********
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
   logic sleeping, irq, wake, ref_select, input_switch;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] cmp_enable;
   dcc_analog_type analog;
   dcc_pins_type pins;
   int num_errors = 0;
   int num_checks = 0;

   dcc_top i_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .analog(analog), .cmp_enable(cmp_enable), .ref_select(ref_select),
      .input_switch(input_switch), .pins(pins), .sleeping(sleeping), .irq(irq), .wake(wake));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // ********
   // helpers
   // ********
   task report_and_stop;
      if (num_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask : chk

   // one apb transfer, held until pready sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      chk("pslverr", 32'h0, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         report_and_stop();
      end
   endtask : apb

   task rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0000_0000);
      chk(name, exp, rd);
   endtask : rdchk

   // ********
   // scenarios
   // ********
   task t_reset;
      rdchk(`DCC_ADDR_CONTROL, 32'h0000_0007, "control");
      rdchk(`DCC_ADDR_FLAGS, 32'h0000_0000, "flags");
      rdchk(`DCC_ADDR_ENABLES, 32'h0000_0000, "enables");
      rdchk(`DCC_ADDR_PORT, 32'h0000_3F30, "port");
      rdchk(12'h010, 32'h0000_0000, "unmapped");
      chk("cmp_enable", 32'h0, {30'h0, cmp_enable});
   endtask : t_reset

   task t_modes;
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, `DCC_ADDR_CONTROL, m);
         rdchk(`DCC_ADDR_CONTROL, m, "mode");
         chk("ref_select", (m == 6), {31'h0, ref_select});
      end
      chk("cmp_enable", 32'h0, {30'h0, cmp_enable});
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_000E);
      @(negedge mclk);
      chk("input_switch", 32'h1, {31'h0, input_switch});
      chk("cmp_enable mux", 32'h3, {30'h0, cmp_enable});
   endtask : t_modes

   task t_change;
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_0006);
      apb(1'b1, `DCC_ADDR_FLAGS, 32'h0000_0000);
      rdchk(`DCC_ADDR_FLAGS, 32'h0000_0000, "flag idle");
      @(posedge mclk);
      analog.ref_gt <= 2'b01;
      repeat (3) @(posedge mclk);
      rdchk(`DCC_ADDR_FLAGS, 32'h0000_0040, "flag set");
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, `DCC_ADDR_FLAGS, 32'h0000_0000);
      rdchk(`DCC_ADDR_FLAGS, 32'h0000_0040, "flag kept");
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_00C6);
      rdchk(`DCC_ADDR_CONTROL, 32'h0000_0046, "outputs");
      apb(1'b1, `DCC_ADDR_FLAGS, 32'h0000_0000);
      rdchk(`DCC_ADDR_FLAGS, 32'h0000_0000, "flag clear");
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_0036);
      rdchk(`DCC_ADDR_CONTROL, 32'h0000_00B6, "inverted");
      apb(1'b1, `DCC_ADDR_FLAGS, 32'h0000_0000);
      apb(1'b1, `DCC_ADDR_FLAGS, 32'h0000_0040);
      rdchk(`DCC_ADDR_FLAGS, 32'h0000_0040, "flag soft");
   endtask : t_change

   task t_irq;
      sleeping <= 1'b1;
      for (int e = 0; e < 8; e++) begin
         apb(1'b1, `DCC_ADDR_ENABLES, e);
         @(negedge mclk);
         chk("irq", (e == 7), {31'h0, irq});
         chk("wake", e % 2, {31'h0, wake});
      end
      apb(1'b1, `DCC_ADDR_FLAGS, 32'h0000_0000);
      @(negedge mclk);
      chk("wake idle", 32'h0, {31'h0, wake});
      @(posedge mclk);
      analog.ref_gt <= 2'b11;
      repeat (3) @(posedge mclk);
      chk("wake sleep", 32'h1, {31'h0, wake});
      rdchk(`DCC_ADDR_CONTROL, 32'h0000_0036, "control kept");
      sleeping <= 1'b0;
      apb(1'b1, `DCC_ADDR_ENABLES, 32'h0000_0000);
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_0007);
      apb(1'b1, `DCC_ADDR_FLAGS, 32'h0000_0000);
      sleeping <= 1'b1;
      analog.ref_gt <= 2'b00;
      repeat (3) @(posedge mclk);
      rdchk(`DCC_ADDR_FLAGS, 32'h0000_0000, "flag off");
      chk("irq off", 32'h0, {31'h0, irq});
      sleeping <= 1'b0;
   endtask : t_irq

   task t_pins;
      apb(1'b1, `DCC_ADDR_PORT, 32'h000F_0F00);
      @(posedge mclk);
      analog.cmp_gt <= 4'hF;
      analog.pin_in <= 6'h3F;
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_0003);
      @(negedge mclk);
      chk("oe_n", 32'h0F, {26'h0, pins.pin_oe_n});
      chk("routed", 32'h3, {30'h0, pins.pin_out[5:4]});
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_0033);
      @(negedge mclk);
      chk("routed inv", 32'h0, {30'h0, pins.pin_out[5:4]});
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_0005);
      @(negedge mclk);
      chk("routed one", 32'h1, {31'h0, pins.pin_out[4]});
      rdchk(`DCC_ADDR_PORT, 32'h000F_0F3F, "digital read");
      apb(1'b1, `DCC_ADDR_PORT, 32'h0000_0F00);
      rdchk(`DCC_ADDR_PORT, 32'h0000_0F30, "analog read");
      apb(1'b1, `DCC_ADDR_CONTROL, 32'h0000_0007);
      apb(1'b1, `DCC_ADDR_PORT, 32'h0000_0F15);
      @(negedge mclk);
      chk("latch out", 32'h0000_0015, {26'h0, pins.pin_out});
   endtask : t_pins

   // ********
   // main sequence
   // ********
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      sleeping = 1'b0;
      analog = '{pin_in: 6'h30, cmp_gt: 4'h0, ref_gt: 2'b00};
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_modes();
      t_change();
      t_irq();
      t_pins();
      report_and_stop();
   end
endmodule : testbench
